//--- pkg/rmu_pkg.sv
// constants and carrier types for the clock register map and update control
`default_nettype none
package rmu_pkg;
    localparam int REG_COUNT = 32;
    localparam int TIME_REGS = 8;
    localparam int PTR_W = 6;
    localparam int BIT_CNT_W = 3;
    localparam int RW_BIT = 7;
    localparam logic [BIT_CNT_W-1:0] BIT_FIRST = 3'h0;
    localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
    localparam logic [BIT_CNT_W-1:0] BIT_STEP = 3'h1;
    localparam logic [PTR_W-1:0] PTR_STEP = 6'h01;
    // register offsets
    localparam int ADDR_SUBSEC = 8'h00;
    localparam int ADDR_SEC = 8'h01;
    localparam int ADDR_MIN = 8'h02;
    localparam int ADDR_HOUR = 8'h03;
    localparam int ADDR_WDAY = 8'h04;
    localparam int ADDR_DATE = 8'h05;
    localparam int ADDR_MONTH = 8'h06;
    localparam int ADDR_YEAR = 8'h07;
    localparam int ADDR_DIG_TRIM = 8'h08;
    localparam int ADDR_WDOG = 8'h09;
    localparam int ADDR_ALARM_ONE_MONTH = 8'h0a;
    localparam int ADDR_ALARM_ONE_DATE = 8'h0b;
    localparam int ADDR_ALARM_ONE_HOUR = 8'h0c;
    localparam int ADDR_ALARM_ONE_MINUTE = 8'h0d;
    localparam int ADDR_ALARM_ONE_SECOND = 8'h0e;
    localparam int ADDR_FLAGS = 8'h0f;
    localparam int ADDR_CD_VALUE = 8'h10;
    localparam int ADDR_CD_CTRL = 8'h11;
    localparam int ADDR_LOAD_CAP = 8'h12;
    localparam int ADDR_SQW = 8'h13;
    localparam int ADDR_AL2_DATE = 8'h15;
    localparam int ADDR_AL2_HOUR = 8'h16;
    localparam int ADDR_AL2_MIN = 8'h17;
    localparam int ADDR_AL2_SEC = 8'h18;
    localparam int ADDR_LAST = 8'h1f;
    // bit masks
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] OSC_STOP_MASK = 8'h80;
    localparam logic [7:0] CENT_MASK = 8'hc0;
    localparam logic [7:0] CENT_STEP = 8'h40;
    localparam logic [7:0] HOUR_MASK = 8'h3f;
    localparam logic [7:0] HALT_MASK = 8'h40;
    localparam logic [7:0] OSC_FAIL_MASK = 8'h04;
    localparam logic [7:0] AF2_MASK = 8'h20;
    localparam logic [7:0] ALARM2_EN_MASK = 8'h02;
    // writable bits per register, 1fh down to 00h
    localparam logic [REG_COUNT*8-1:0] WRITE_MASK =
        256'hffffffffffffffffffbfff1ff3ffe3fffcffffffffffffffff1f3f07ff7fffff;
    // bcd limits
    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_ONE = 8'h01;
    localparam logic [7:0] HSEC_TOP = 8'h99;
    localparam logic [7:0] SEC_TOP = 8'h59;
    localparam logic [7:0] MIN_TOP = 8'h59;
    localparam logic [7:0] HOUR_TOP = 8'h23;
    localparam logic [7:0] WDAY_TOP = 8'h07;
    localparam logic [7:0] DATE_TOP = 8'h31;
    localparam logic [7:0] MONTH_TOP = 8'h12;
    localparam logic [7:0] YEAR_TOP = 8'h99;
    // timing
    localparam int CORE_CLK_HZ = 10_000_000;
    localparam int TICK_PERIOD_US = 10_000;
    localparam int TICK_CYCLES = CORE_CLK_HZ / 1_000_000 * TICK_PERIOD_US;

    typedef struct packed {
        logic [PTR_W-1:0] addr;
        logic [7:0] data;
    } rmu_wr_t;
    typedef struct packed {
        logic outLevel;
        logic freqTestBit;
        logic digTrimSign;
        logic [4:0] digTrimMagnitude;
    } rmu_dig_trim_t;
    typedef struct packed {
        logic oscFailIrqEn;
        logic [4:0] wdogMultiplier;
        logic [1:0] wdogResolution;
    } rmu_wdog_t;
    typedef struct packed {
        logic alarmOneIrqEn;
        logic squareWaveEn;
        logic alarmOnBatteryEn;
        logic [4:0] month;
    } rmu_al_month_t;
    typedef struct packed {
        logic repeatA;
        logic repeatB;
        logic [5:0] value;
    } rmu_rpt_pair_t;
    typedef struct packed {
        logic repeatBit;
        logic [6:0] value;
    } rmu_rpt_byte_t;
    typedef struct packed {
        logic countdownEn;
        logic countdownIrqOrPulse;
        logic countdownIrqEn;
        logic [2:0] zero;
        logic [1:0] countdownSourceSel;
    } rmu_cd_ctrl_t;
    typedef struct packed {
        logic loadCapSign;
        logic [6:0] loadCapMagnitude;
    } rmu_load_cap_t;
    typedef struct packed {
        logic [3:0] squareWaveRateSel;
        logic [1:0] zero;
        logic alarmTwoEn;
        logic otpCtl;
    } rmu_sqw_t;
    typedef struct packed {
        rmu_dig_trim_t digTrim;
        rmu_wdog_t wdog;
        rmu_al_month_t alarmOneMonth;
        logic [4:0] alarmOneRepeat;
        logic [4:0] alarmTwoRepeat;
        logic [7:0] countdownValue;
        rmu_cd_ctrl_t countdownCtrl;
        rmu_load_cap_t loadCap;
        rmu_sqw_t squareWave;
    } rmu_cfg_t;
endpackage
`default_nettype wire

//--- rtl/rmu_ctrl.sv
// clock register file, serial access and user-copy update control
`timescale 1ns/100ps
`default_nettype none
module rmu_ctrl #(
    parameter int TICK_CYCLES = rmu_pkg::TICK_CYCLES
) (
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // serial link
    input wire logic spiSclk,
    input wire logic spiCeB,
    input wire logic spiSdi,
    output logic spiSdo,
    output logic spiSdoOeB,
    // monitors
    input wire logic pwrFail,
    input wire logic oscFailEvt,
    // status and configuration
    output logic oscFailIrq,
    output logic oscStopped,
    output logic updateHalted,
    output var rmu_pkg::rmu_cfg_t cfg
);
    import rmu_pkg::*;

    localparam int DIV_W = $clog2(TICK_CYCLES);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
    localparam logic [DIV_W-1:0] DIV_STEP = DIV_W'(1);

    // link domain state
    logic [BIT_CNT_W-1:0] bitCnt;
    logic [6:0] rxShift;
    logic [7:0] txShift;
    logic [PTR_W-1:0] ptr;
    logic dataPhase;
    logic writeMode;
    logic timeSel;
    logic wrTgl;
    rmu_wr_t wrWord;

    // core domain state
    logic [2:0] pfSync;
    logic [2:0] ofSync;
    logic [2:0] wrSync;
    logic [1:0] tsSync;
    logic [DIV_W-1:0] divCnt;
    logic [7:0] regs [REG_COUNT];
    logic [7:0] regView [REG_COUNT];
    logic [7:0] intTime [TIME_REGS];
    logic [7:0] nextTime [TIME_REGS];
    logic [8:0] incR;
    logic carry;

    function automatic logic [8:0] bcdInc(
        input logic [7:0] v,
        input logic [7:0] top,
        input logic [7:0] bottom
    );
        if (v >= top) begin
            bcdInc = {1'b1, bottom};
        end else if (v[3:0] == 4'h9) begin
            bcdInc = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            bcdInc = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // link side decode
    wire frameRstB = rst_b & ~spiCeB;
    wire [7:0] rxByte = {rxShift, spiSdi};
    wire byteDone = (bitCnt == BIT_LAST);
    wire [PTR_W-1:0] nextPtr = dataPhase ? ptr + PTR_STEP : rxByte[PTR_W-1:0];
    wire nextInTime = (nextPtr <= PTR_W'(ADDR_YEAR));
    wire ptrMapped = (ptr <= PTR_W'(ADDR_LAST));
    wire [7:0] rdByte = ptrMapped ? regView[ptr[4:0]] : 8'h00;

    // frame state, cleared while chip enable is high
    always_ff @(posedge spiSclk or negedge frameRstB) begin
        if (!frameRstB) begin
            bitCnt <= BIT_FIRST;
            rxShift <= 7'h00;
            ptr <= 6'h00;
            dataPhase <= 1'b0;
            writeMode <= 1'b0;
            timeSel <= 1'b0;
        end else begin
            bitCnt <= bitCnt + BIT_STEP;
            rxShift <= rxByte[6:0];
            if (byteDone) begin
                ptr <= nextPtr;
                dataPhase <= 1'b1;
                timeSel <= nextInTime;
                if (!dataPhase) begin
                    writeMode <= rxByte[RW_BIT];
                end
            end
        end
    end

    // write word handed to the core by toggle
    always_ff @(posedge spiSclk or negedge rst_b) begin
        if (!rst_b) begin
            wrWord <= '0;
            wrTgl <= 1'b0;
        end else if (byteDone && dataPhase && writeMode) begin
            wrWord <= '{addr: ptr, data: rxByte};
            wrTgl <= ~wrTgl;
        end
    end

    // read data shifted out on falling edges
    always_ff @(negedge spiSclk or negedge frameRstB) begin
        if (!frameRstB) begin
            txShift <= 8'h00;
        end else if (dataPhase && bitCnt == BIT_FIRST) begin
            txShift <= rdByte;
        end else begin
            txShift <= {txShift[6:0], 1'b0};
        end
    end

    assign spiSdo = txShift[7];
    assign spiSdoOeB = spiCeB | writeMode | ~dataPhase;

    // crossings into the core domain
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pfSync <= 3'h0;
            ofSync <= 3'h0;
            wrSync <= 3'h0;
            tsSync <= 2'h0;
        end else begin
            pfSync <= {pfSync[1:0], pwrFail};
            ofSync <= {ofSync[1:0], oscFailEvt};
            wrSync <= {wrSync[1:0], wrTgl};
            tsSync <= {tsSync[0], timeSel};
        end
    end

    wire pfRise = pfSync[1] & ~pfSync[2];
    wire ofRise = ofSync[1] & ~ofSync[2];
    wire hostWr = wrSync[1] ^ wrSync[2];
    wire [PTR_W-1:0] hostAddr = wrWord.addr;
    wire [7:0] hostData = wrWord.data;
    wire timeWr = hostWr && (hostAddr <= PTR_W'(ADDR_YEAR));
    wire tick = (divCnt == DIV_LAST);
    wire frozen = updateHalted | tsSync[1];
    wire xfer = tick & ~frozen;
    wire alarmTwoOn = |(regs[ADDR_SQW] & ALARM2_EN_MASK);

    assign oscStopped = |(intTime[ADDR_SEC] & OSC_STOP_MASK);
    assign updateHalted = |(regs[ADDR_ALARM_ONE_HOUR] & HALT_MASK);

    // hundredths divider
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            divCnt <= '0;
        end else if (timeWr || oscStopped || tick) begin
            divCnt <= '0;
        end else begin
            divCnt <= divCnt + DIV_STEP;
        end
    end

    // bcd counter chain
    always_comb begin
        for (int k = 0; k < TIME_REGS; k++) begin
            nextTime[k] = intTime[k];
        end
        incR = bcdInc(intTime[ADDR_SUBSEC], HSEC_TOP, BCD_ZERO);
        nextTime[ADDR_SUBSEC] = incR[7:0];
        carry = incR[8];
        if (carry) begin
            incR = bcdInc(intTime[ADDR_SEC] & ~OSC_STOP_MASK, SEC_TOP, BCD_ZERO);
            nextTime[ADDR_SEC] = (intTime[ADDR_SEC] & OSC_STOP_MASK) | incR[7:0];
            carry = incR[8];
        end
        if (carry) begin
            incR = bcdInc(intTime[ADDR_MIN], MIN_TOP, BCD_ZERO);
            nextTime[ADDR_MIN] = incR[7:0];
            carry = incR[8];
        end
        if (carry) begin
            incR = bcdInc(intTime[ADDR_HOUR] & HOUR_MASK, HOUR_TOP, BCD_ZERO);
            nextTime[ADDR_HOUR] = (intTime[ADDR_HOUR] & CENT_MASK) | incR[7:0];
            carry = incR[8];
        end
        if (carry) begin
            incR = bcdInc(intTime[ADDR_WDAY], WDAY_TOP, BCD_ONE);
            nextTime[ADDR_WDAY] = incR[7:0];
            incR = bcdInc(intTime[ADDR_DATE], DATE_TOP, BCD_ONE);
            nextTime[ADDR_DATE] = incR[7:0];
            carry = incR[8];
        end
        if (carry) begin
            incR = bcdInc(intTime[ADDR_MONTH], MONTH_TOP, BCD_ONE);
            nextTime[ADDR_MONTH] = incR[7:0];
            carry = incR[8];
        end
        if (carry) begin
            incR = bcdInc(intTime[ADDR_YEAR], YEAR_TOP, BCD_ZERO);
            nextTime[ADDR_YEAR] = incR[7:0];
            carry = incR[8];
        end
        if (carry) begin
            nextTime[ADDR_HOUR] = (((intTime[ADDR_HOUR] & CENT_MASK) + CENT_STEP) & CENT_MASK)
                | (nextTime[ADDR_HOUR] & HOUR_MASK);
        end
    end

    // register file, one entry per address
    for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
        wire hit = hostWr && (hostAddr == PTR_W'(i));
        wire [7:0] wrMask = WRITE_MASK[i*8 +: 8];
        wire [7:0] wrVal = hit ? (hostData & wrMask) : regs[i];
        wire [7:0] setVal;
        wire [7:0] loadVal;
        if (i == ADDR_ALARM_ONE_HOUR) begin : g_halt
            assign setVal = pfRise ? HALT_MASK : 8'h00;
        end else if (i == ADDR_FLAGS) begin : g_flag
            assign setVal = ofRise ? OSC_FAIL_MASK : 8'h00;
        end else begin : g_none
            assign setVal = 8'h00;
        end
        if (i == ADDR_FLAGS) begin : g_view
            assign regView[i] = alarmTwoOn ? regs[i] : (regs[i] & ~AF2_MASK);
        end else begin : g_plain
            assign regView[i] = regs[i];
        end
        if (i < TIME_REGS) begin : g_time
            assign loadVal = (xfer && !hit) ? nextTime[i] : wrVal;
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    intTime[i] <= REG_RESET;
                end else if (hit) begin
                    intTime[i] <= hostData & wrMask;
                end else if (tick) begin
                    intTime[i] <= nextTime[i];
                end
            end
        end else begin : g_ctl
            assign loadVal = wrVal;
        end
        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                regs[i] <= REG_RESET;
            end else begin
                regs[i] <= loadVal | setVal; // set wins over a clearing write
            end
        end
    end

    // byte views of alarm registers
    rmu_rpt_pair_t al1Date;
    rmu_rpt_byte_t al1Hour;
    rmu_rpt_byte_t al1Min;
    rmu_rpt_byte_t al1Sec;
    rmu_rpt_pair_t al2Date;
    rmu_rpt_byte_t al2Hour;
    rmu_rpt_byte_t al2Min;
    rmu_rpt_byte_t al2Sec;
    assign al1Date = rmu_rpt_pair_t'(regs[ADDR_ALARM_ONE_DATE]);
    assign al1Hour = rmu_rpt_byte_t'(regs[ADDR_ALARM_ONE_HOUR]);
    assign al1Min = rmu_rpt_byte_t'(regs[ADDR_ALARM_ONE_MINUTE]);
    assign al1Sec = rmu_rpt_byte_t'(regs[ADDR_ALARM_ONE_SECOND]);
    assign al2Date = rmu_rpt_pair_t'(regs[ADDR_AL2_DATE]);
    assign al2Hour = rmu_rpt_byte_t'(regs[ADDR_AL2_HOUR]);
    assign al2Min = rmu_rpt_byte_t'(regs[ADDR_AL2_MIN]);
    assign al2Sec = rmu_rpt_byte_t'(regs[ADDR_AL2_SEC]);

    // configuration fields for the rest of the clock
    assign cfg = '{
        digTrim: rmu_dig_trim_t'(regs[ADDR_DIG_TRIM]),
        wdog: rmu_wdog_t'(regs[ADDR_WDOG]),
        alarmOneMonth: rmu_al_month_t'(regs[ADDR_ALARM_ONE_MONTH]),
        alarmOneRepeat: {al1Date.repeatB, al1Date.repeatA, al1Hour.repeatBit,
            al1Min.repeatBit, al1Sec.repeatBit},
        alarmTwoRepeat: {al2Date.repeatB, al2Date.repeatA, al2Hour.repeatBit,
            al2Min.repeatBit, al2Sec.repeatBit},
        countdownValue: regs[ADDR_CD_VALUE],
        countdownCtrl: rmu_cd_ctrl_t'(regs[ADDR_CD_CTRL]),
        loadCap: rmu_load_cap_t'(regs[ADDR_LOAD_CAP]),
        squareWave: rmu_sqw_t'(regs[ADDR_SQW])
    };

    // oscillator fail interrupt
    wire oscFailSet = |(regs[ADDR_FLAGS] & OSC_FAIL_MASK);
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            oscFailIrq <= 1'b0;
        end else begin
            oscFailIrq <= oscFailSet & cfg.wdog.oscFailIrqEn;
        end
    end
endmodule
`default_nettype wire

//--- verification/rmu_ctrl_props.sv
// concurrent checks on the register map ports
`timescale 1ns/100ps
`default_nettype none
module rmu_ctrl_props #(
    parameter int TICK_CYCLES = 20
) (
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // serial link
    input wire logic spiCeB,
    input wire logic spiSdoOeB,
    // monitors
    input wire logic pwrFail,
    input wire logic oscFailEvt,
    // status and configuration
    input wire logic oscFailIrq,
    input wire logic updateHalted,
    input wire rmu_pkg::rmu_cfg_t cfg
);
    import rmu_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_ce_idle;
        spiCeB [*6];
    endsequence
    sequence s_irq_armed;
        $rose(oscFailEvt) ##0 cfg.wdog.oscFailIrqEn [*6];
    endsequence
    chk_halt_on_fail: assert property ($rose(pwrFail) |-> ##[1:4] updateHalted)
        else $error("halt flag not set after power fail");
    chk_halt_held: assert property (s_ce_idle ##0 updateHalted |=> updateHalted)
        else $error("halt flag dropped without a host write");
    chk_cfg_idle: assert property (s_ce_idle |=> $stable(cfg))
        else $error("configuration changed without a host write");
    chk_irq_gated: assert property (!cfg.wdog.oscFailIrqEn |=> !oscFailIrq)
        else $error("interrupt raised while disabled");
    chk_irq_on_event: assert property (s_irq_armed |-> oscFailIrq)
        else $error("interrupt missing after oscillator fail");
    chk_irq_cause: assert property ($rose(oscFailIrq) |-> $past(cfg.wdog.oscFailIrqEn))
        else $error("interrupt rose without its enable");
    chk_oe_in_frame: assert property (spiCeB |-> spiSdoOeB)
        else $error("output driven outside a frame");
    chk_cd_zero: assert property (cfg.countdownCtrl.zero == 3'h0)
        else $error("countdown control zero bits set");
    chk_sqw_zero: assert property (cfg.squareWave.zero == 2'h0)
        else $error("square wave zero bits set");
endmodule
bind rmu_ctrl rmu_ctrl_props #(.TICK_CYCLES(TICK_CYCLES)) rmu_ctrl_props_i (.core_clk(core_clk), .rst_b(rst_b),
    .spiCeB(spiCeB), .spiSdoOeB(spiSdoOeB), .pwrFail(pwrFail), .oscFailEvt(oscFailEvt),
    .oscFailIrq(oscFailIrq), .updateHalted(updateHalted), .cfg(cfg));
`default_nettype wire

//--- verification/rmu_host_model.sv
// serial host model, mode 0, link clock 160 ns
`timescale 1ns/100ps
`default_nettype none
module rmu_host_model (
    // link
    output logic spiSclk,
    output logic spiCeB,
    output logic spiSdi,
    input wire logic spiSdo,
    input wire logic spiSdoOeB
);
    initial begin
        spiSclk = 1'b0;
        spiCeB = 1'b1;
        spiSdi = 1'b0;
    end
    // msb first, device samples on rising edge
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spiSdi = tx[i];
            #80 spiSclk = 1'b1;
            rx[i] = spiSdoOeB ? 1'bx : spiSdo;
            #80 spiSclk = 1'b0;
        end
    endtask
    task automatic frame_start();
        spiCeB = 1'b0;
        #80;
    endtask
    // chip enable high ends the frame, clock stands still
    task automatic frame_end();
        #80 spiCeB = 1'b1;
        spiSdi = ~spiSdi;
        #500;
    endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the register map
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import rmu_pkg::*;
    localparam int TICKS = 20;
    logic core_clk, rst_b, pwrFail, oscFailEvt;
    wire logic spiSclk, spiCeB, spiSdi, spiSdo, spiSdoOeB, oscFailIrq, oscStopped, updateHalted;
    rmu_cfg_t cfg;
    int num_errors = 0;
    int checks_done = 0;
    logic [7:0] ex [33];
    logic [7:0] rb, a0, cp;
    rmu_ctrl #(.TICK_CYCLES(TICKS)) rmu_ctrl_i (.core_clk(core_clk), .rst_b(rst_b), .spiSclk(spiSclk),
        .spiCeB(spiCeB), .spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoOeB(spiSdoOeB), .pwrFail(pwrFail),
        .oscFailEvt(oscFailEvt), .oscFailIrq(oscFailIrq), .oscStopped(oscStopped),
        .updateHalted(updateHalted), .cfg(cfg));
    rmu_host_model rmu_host_model_i (.spiSclk(spiSclk), .spiCeB(spiCeB), .spiSdi(spiSdi), .spiSdo(spiSdo),
        .spiSdoOeB(spiSdoOeB));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic chkcfg(input rmu_cfg_t exp);
        checks_done++;
        if (cfg !== exp) begin
            num_errors++;
            $display("unexpected cfg: expected %h, seen %h", exp, cfg);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] r;
        rmu_host_model_i.frame_start();
        rmu_host_model_i.xfer({2'b10, a}, r);
        rmu_host_model_i.xfer(d, r);
        rmu_host_model_i.frame_end();
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        rmu_host_model_i.frame_start();
        rmu_host_model_i.xfer({2'b00, a}, d);
        rmu_host_model_i.xfer(8'h00, d);
        rmu_host_model_i.frame_end();
    endtask
    function automatic logic [7:0] ok(input logic c);
        return {7'h0, c};
    endfunction
    function automatic int elapsed(input logic [7:0] a, input logic [7:0] b);
        return (b[7:4] * 10 + b[3:0] + 100 - a[7:4] * 10 - a[3:0]) % 100;
    endfunction
    // burst read 08h to 20h, then the exported fields
    task automatic check_regs();
        logic [7:0] r;
        rmu_host_model_i.frame_start();
        rmu_host_model_i.xfer(8'h08, r);
        for (int a = 8; a < 33; a++) begin
            rmu_host_model_i.xfer(8'h00, r);
            chk8("register byte", ex[a], r);
        end
        rmu_host_model_i.frame_end();
        chkcfg({ex[8], ex[9], ex[10], ex[11][6], ex[11][7], ex[12][7], ex[13][7], ex[14][7], ex[21][6],
            ex[21][7], ex[22][7], ex[23][7], ex[24][7], ex[16], ex[17], ex[18], ex[19]});
        chk8("halt flag", ok(ex[12][6]), ok(updateHalted));
    endtask
    task automatic write_regs(input logic p);
        logic [7:0] r;
        rmu_host_model_i.frame_start();
        rmu_host_model_i.xfer(8'h88, r);
        for (int a = 8; a < 32; a++) begin
            ex[a] = (8'h5a ^ 8'(a * 29) ^ {8{p}}) & WRITE_MASK[a*8 +: 8];
            rmu_host_model_i.xfer(ex[a], r);
        end
        rmu_host_model_i.frame_end();
        if (!ex[ADDR_SQW][1]) ex[ADDR_FLAGS][5] = 1'b0;
        check_regs();
        $display("register pass %0d done", p);
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #2_000_000;
        num_errors++;
        end_of_test();
    end
    initial begin
        rst_b = 1'b0;
        pwrFail = 1'b0;
        oscFailEvt = 1'b0;
        for (int a = 0; a < 33; a++) ex[a] = 8'h00;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        rst_b = 1'b1;
        check_regs();
        write_regs(1'b0);
        write_regs(1'b1);
        wr(6'h0f, 8'h00);
        chk8("irq idle", 8'h00, ok(oscFailIrq));
        @(negedge core_clk);
        oscFailEvt = 1'b1;
        repeat (8) @(negedge core_clk);
        chk8("irq on fail", 8'h01, ok(oscFailIrq));
        rd(6'h0f, rb);
        chk8("fail flag", OSC_FAIL_MASK, rb);
        wr(6'h09, 8'h00);
        chk8("irq masked", 8'h00, ok(oscFailIrq));
        $display("test oscillator fail done");
        wr(6'h0c, 8'h00);
        wr(6'h01, 8'h00);
        wr(6'h03, 8'he3);
        rd(6'h03, rb);
        chk8("century hours", 8'he3, rb);
        rd(6'h00, a0);
        rmu_host_model_i.frame_start();
        rmu_host_model_i.xfer(8'h00, rb);
        repeat (3) @(negedge core_clk);
        cp = rmu_ctrl_i.regs[0];
        #(40 * TICKS * 100);
        chk8("frozen copy", cp, rmu_ctrl_i.regs[0]);
        rmu_host_model_i.xfer(8'h00, rb);
        rmu_host_model_i.frame_end();
        chk8("frozen time", 8'h01, ok(elapsed(a0, rb) < 5));
        #(20 * TICKS * 100);
        rd(6'h00, a0);
        chk8("resumed time", 8'h01, ok(elapsed(rb, a0) > 10));
        $display("test update freeze done");
        @(negedge core_clk);
        pwrFail = 1'b1;
        repeat (5) @(negedge core_clk);
        chk8("halt on fail", 8'h01, ok(updateHalted));
        rd(6'h00, a0);
        #(20 * TICKS * 100);
        rd(6'h00, rb);
        chk8("halted time", a0, rb);
        @(negedge core_clk);
        pwrFail = 1'b0;
        wr(6'h0c, 8'h00);
        #(20 * TICKS * 100);
        rd(6'h00, a0);
        chk8("released time", 8'h01, ok(elapsed(rb, a0) > 10));
        $display("test power fail done");
        wr(6'h01, OSC_STOP_MASK);
        chk8("stopped", 8'h01, ok(oscStopped));
        rd(6'h00, a0);
        #(20 * TICKS * 100);
        rd(6'h00, rb);
        chk8("stopped time", a0, rb);
        wr(6'h01, 8'h00);
        chk8("restarted", 8'h00, ok(oscStopped));
        $display("test oscillator stop done");
        end_of_test();
    end
endmodule
`default_nettype wire
